// ---- hw/msd_dma.sv ----
`timescale 1ns/1ps
// What this block does
// - Two identical controllers, eight independent streams each.
// - Stream direction is peripheral-to-memory, memory-to-peripheral or memory-to-memory.
// - Each stream packs data in its own FIFO; bus beats are grouped in bursts.
// - Circular mode reloads address and count at buffer end and continues.
// - Double buffering alternates between two memory buffers at each completion.
// - Peripheral streams start on hardware request lines or on a software request bit; memory-to-memory streams start on enable alone.
// - Source and destination item sizes are independent; data is packed between them.
// - Each controller is a 32-bit master port toward the bus matrix.
module msd_dma #(
	parameter int unsigned BURST = msd_pkg::BURST
) (
	input  logic                               pclk,
	input  logic                               presetn,
	input  logic                               psel,
	input  logic                               penable,
	input  logic                               pwrite,
	input  logic [11:0]                        paddr,
	input  logic [31:0]                        pwdata,
	output logic [31:0]                        prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  logic [msd_pkg::NCTRL*msd_pkg::NSTR-1:0] periph_req,
	output msd_pkg::msd_mreq_t                 mreq [msd_pkg::NCTRL],
	input  msd_pkg::msd_mrsp_t                 mrsp [msd_pkg::NCTRL],
	output logic                               irq
);
	localparam int unsigned NC = msd_pkg::NCTRL;
	localparam int unsigned NS = msd_pkg::NSTR;
	localparam int unsigned NT = NC * NS;

	// ============================================================
	// Helpers
	function automatic logic [3:0] nbytes(input logic [1:0] sz);
		nbytes = (sz == 2'h0) ? 4'h1 : (sz == 2'h1) ? 4'h2 : 4'h4;
	endfunction

	function automatic logic [31:0] lanes(input logic [3:0] nb);
		lanes = (nb == 4'h1) ? 32'h0000_00FF : (nb == 4'h2) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
	endfunction

	msd_pkg::msd_cfg_t cfg_q  [NT];
	logic [15:0]       cnt_q  [NT];
	logic [31:0]       padr_q [NT];
	logic [31:0]       m0_q   [NT];
	logic [31:0]       m1_q   [NT];
	logic [31:0]       sts_q  [NC];
	logic [31:0]       mask_q [NC];
	logic [31:0]       set_v  [NC];
	logic [NT-1:0]     ev_ht;
	logic [NT-1:0]     ev_tc;
	logic [NT-1:0]     ev_te;
	logic [NT-1:0]     done;
	logic [NT-1:0]     ct;

	// ============================================================
	// APB decode
	logic        sel_c;
	logic [9:0]  lofs;
	logic [4:0]  rofs;
	logic [3:0]  gi;
	logic        is_str;
	logic        is_stat;
	logic        is_mask;
	logic        hit;
	logic        wr_acc;
	logic [31:0] rd_val;

	assign sel_c   = paddr[msd_pkg::CSEL_BIT];
	assign lofs    = paddr[9:0];
	assign rofs    = paddr[4:0];
	assign gi      = {sel_c, paddr[7:5]};
	assign is_str  = (lofs < msd_pkg::STR_SPAN) &&
	                 (rofs == msd_pkg::OFS_CFG || rofs == msd_pkg::OFS_CNT ||
	                  rofs == msd_pkg::OFS_PADR || rofs == msd_pkg::OFS_M0 ||
	                  rofs == msd_pkg::OFS_M1);
	assign is_stat = (lofs == msd_pkg::OFS_STAT);
	assign is_mask = (lofs == msd_pkg::OFS_MASK);
	assign hit     = ~paddr[11] & (is_str | is_stat | is_mask);
	assign wr_acc  = psel & penable & pwrite & hit;
	// Zero wait state: data is prepared during setup
	assign pready  = 1'b1;

	// Read mux; the current-target bit is live engine state
	always_comb begin
		msd_pkg::msd_cfg_t t;
		t = cfg_q[gi];
		t.ct = ct[gi];
		rd_val = '0;
		if (is_stat) begin
			rd_val = sts_q[sel_c];
		end else if (is_mask) begin
			rd_val = mask_q[sel_c];
		end else if (is_str) begin
			case (rofs)
				msd_pkg::OFS_CFG:  rd_val = t;
				msd_pkg::OFS_CNT:  rd_val = {16'h0000, cnt_q[gi]};
				msd_pkg::OFS_PADR: rd_val = padr_q[gi];
				msd_pkg::OFS_M0:   rd_val = m0_q[gi];
				msd_pkg::OFS_M1:   rd_val = m1_q[gi];
				default:           rd_val = '0;
			endcase
		end
	end

	// Answer registered in setup phase; unmapped gives pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= msd_pkg::REG_RST;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= (hit && !pwrite) ? rd_val : '0;
			pslverr <= ~hit;
		end
	end

	// ============================================================
	// Stream configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NT; i++) begin
				cfg_q[i]  <= msd_pkg::msd_cfg_t'(msd_pkg::REG_RST);
				cnt_q[i]  <= msd_pkg::CNT_RST;
				padr_q[i] <= msd_pkg::REG_RST;
				m0_q[i]   <= msd_pkg::REG_RST;
				m1_q[i]   <= msd_pkg::REG_RST;
			end
		end else begin
			// Engine ends a one-shot transfer by dropping enable
			for (int i = 0; i < NT; i++) begin
				if (done[i]) begin
					cfg_q[i].en <= 1'b0;
				end
			end
			if (wr_acc && is_str) begin
				case (rofs)
					msd_pkg::OFS_CFG:  cfg_q[gi]  <= msd_pkg::msd_cfg_t'(pwdata);
					msd_pkg::OFS_CNT:  cnt_q[gi]  <= pwdata[15:0];
					msd_pkg::OFS_PADR: padr_q[gi] <= pwdata;
					msd_pkg::OFS_M0:   m0_q[gi]   <= pwdata;
					msd_pkg::OFS_M1:   m1_q[gi]   <= pwdata;
					default:           cnt_q[gi]  <= cnt_q[gi];
				endcase
			end
		end
	end

	// ============================================================
	// Status flags and interrupt
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			set_v[c] = '0;
			for (int s = 0; s < NS; s++) begin
				set_v[c][s*msd_pkg::FLG_W+msd_pkg::FLG_HT] = ev_ht[c*NS+s];
				set_v[c][s*msd_pkg::FLG_W+msd_pkg::FLG_TC] = ev_tc[c*NS+s];
				set_v[c][s*msd_pkg::FLG_W+msd_pkg::FLG_TE] = ev_te[c*NS+s];
			end
		end
	end

	// Write-one-to-clear; a same-cycle event keeps its bit set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NC; c++) begin
				sts_q[c]  <= msd_pkg::REG_RST;
				mask_q[c] <= msd_pkg::REG_RST;
			end
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (wr_acc && is_stat && sel_c == c[0]) begin
					sts_q[c] <= (sts_q[c] & ~pwdata) | set_v[c];
				end else begin
					sts_q[c] <= sts_q[c] | set_v[c];
				end
				if (wr_acc && is_mask && sel_c == c[0]) begin
					mask_q[c] <= pwdata;
				end
			end
		end
	end

	// One level output for all unmasked flags
	always_comb begin
		irq = 1'b0;
		for (int c = 0; c < NC; c++) begin
			irq = irq | (|(sts_q[c] & mask_q[c]));
		end
	end

	// ============================================================
	// Transfer engines, one per controller
	for (genvar c = 0; c < NC; c++) begin : g_ctl
		localparam int unsigned B = c * NS;
		msd_pkg::msd_state_t st_q;
		msd_pkg::msd_mreq_t  mq_q;
		logic [2:0]          gs_q;
		logic                wr_q;
		logic [7:0]          bl_q;
		logic [15:0]         rem_q  [NS];
		logic [31:0]         pa_q   [NS];
		logic [31:0]         ma_q   [NS];
		logic [63:0]         buf_q  [NS];
		logic [3:0]          fill_q [NS];
		logic [NS-1:0]       ct_q;
		logic [NS-1:0]       run_q;
		logic [NS-1:0]       ht_q;
		logic [NS-1:0]       tc_q;
		logic [NS-1:0]       te_q;
		logic [NS-1:0]       dn_q;
		logic [NS-1:0]       crd;
		logic [NS-1:0]       cwr;
		logic [NS-1:0]       elig;
		logic [2:0]          pick;
		logic                found;
		logic                lock;
		logic [1:0]          bp;

		// Eligibility and arbitration
		always_comb begin
			for (int s = 0; s < NS; s++) begin
				crd[s]  = (rem_q[s] != 16'h0000) &&
				          (fill_q[s] + nbytes(cfg_q[B+s].ssize) <= msd_pkg::BUFB);
				cwr[s]  = fill_q[s] >= nbytes(cfg_q[B+s].dsize);
				elig[s] = cfg_q[B+s].en && run_q[s] && (crd[s] || cwr[s]) &&
				          (cfg_q[B+s].dir == msd_pkg::DIR_M2M || cfg_q[B+s].swreq ||
				           periph_req[B+s]);
			end
			lock  = (bl_q != 8'h00) && elig[gs_q];
			found = 1'b0;
			pick  = 3'h0;
			bp    = 2'h0;
			for (int s = 0; s < NS; s++) begin
				// Strictly greater keeps the lower index on ties
				if (elig[s] && (!found || cfg_q[B+s].prio > bp)) begin
					pick  = 3'(s);
					bp    = cfg_q[B+s].prio;
					found = 1'b1;
				end
			end
			if (lock) begin
				pick = gs_q;
			end
		end

		// Beat sequencing, packing and reload
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				st_q  <= msd_pkg::ST_IDLE;
				mq_q  <= '0;
				gs_q  <= 3'h0;
				wr_q  <= 1'b0;
				bl_q  <= 8'h00;
				ct_q  <= '0;
				run_q <= '0;
				ht_q  <= '0;
				tc_q  <= '0;
				te_q  <= '0;
				dn_q  <= '0;
				for (int s = 0; s < NS; s++) begin
					rem_q[s]  <= 16'h0000;
					pa_q[s]   <= 32'h0000_0000;
					ma_q[s]   <= 32'h0000_0000;
					buf_q[s]  <= 64'h0000_0000_0000_0000;
					fill_q[s] <= 4'h0;
				end
			end else begin
				ht_q <= '0;
				tc_q <= '0;
				te_q <= '0;
				dn_q <= '0;
				// Snapshot count and addresses on enable; sizes, direction and the half-transfer point still follow the live registers
				for (int s = 0; s < NS; s++) begin
					if (cfg_q[B+s].en && !run_q[s]) begin
						run_q[s]  <= 1'b1;
						rem_q[s]  <= cnt_q[B+s];
						pa_q[s]   <= padr_q[B+s];
						ma_q[s]   <= m0_q[B+s];
						ct_q[s]   <= 1'b0;
						buf_q[s]  <= '0;
						fill_q[s] <= 4'h0;
					end else if (!cfg_q[B+s].en) begin
						run_q[s] <= 1'b0;
					end
				end
				unique case (st_q)
					msd_pkg::ST_IDLE: begin
						if (found) begin
							gs_q          <= pick;
							wr_q          <= cwr[pick];
							bl_q          <= lock ? bl_q - 8'h01 : 8'(BURST - 1);
							st_q          <= msd_pkg::ST_XFER;
							mq_q.valid    <= 1'b1;
							mq_q.write    <= cwr[pick];
							mq_q.wdata    <= buf_q[pick][31:0];
							if (cwr[pick]) begin
								mq_q.size <= cfg_q[B+pick].dsize;
								mq_q.addr <= (cfg_q[B+pick].dir == msd_pkg::DIR_M2P) ?
								             pa_q[pick] : ma_q[pick];
							end else begin
								mq_q.size <= cfg_q[B+pick].ssize;
								mq_q.addr <= (cfg_q[B+pick].dir == msd_pkg::DIR_M2P) ?
								             ma_q[pick] : pa_q[pick];
							end
						end
					end
					msd_pkg::ST_XFER: begin
						if (mrsp[c].ready) begin
							mq_q.valid <= 1'b0;
							st_q       <= msd_pkg::ST_IDLE;
							if (mrsp[c].err) begin
								te_q[gs_q] <= 1'b1;
								dn_q[gs_q] <= 1'b1;
								bl_q       <= 8'h00;
							end else if (wr_q) begin
								// Drain destination item from the low bytes
								buf_q[gs_q]  <= buf_q[gs_q] >> {nbytes(cfg_q[B+gs_q].dsize), 3'b000};
								fill_q[gs_q] <= fill_q[gs_q] - nbytes(cfg_q[B+gs_q].dsize);
								if (cfg_q[B+gs_q].dir != msd_pkg::DIR_M2P) begin
									ma_q[gs_q] <= ma_q[gs_q] + nbytes(cfg_q[B+gs_q].dsize);
								end
								if (rem_q[gs_q] == 16'h0000 &&
								    fill_q[gs_q] == nbytes(cfg_q[B+gs_q].dsize)) begin
									tc_q[gs_q] <= 1'b1;
									bl_q       <= 8'h00;
									if (cfg_q[B+gs_q].circ || cfg_q[B+gs_q].dbm) begin
										rem_q[gs_q] <= cnt_q[B+gs_q];
										pa_q[gs_q]  <= padr_q[B+gs_q];
										ma_q[gs_q]  <= m0_q[B+gs_q];
										if (cfg_q[B+gs_q].dbm) begin
											ct_q[gs_q] <= ~ct_q[gs_q];
											ma_q[gs_q] <= ct_q[gs_q] ? m0_q[B+gs_q] :
											              m1_q[B+gs_q];
										end
									end else begin
										dn_q[gs_q] <= 1'b1;
									end
								end
							end else begin
								// Append source item above the bytes held
								buf_q[gs_q]  <= buf_q[gs_q] |
								    ({32'h0000_0000, mrsp[c].rdata &
								      lanes(nbytes(cfg_q[B+gs_q].ssize))} << {fill_q[gs_q], 3'b000});
								fill_q[gs_q] <= fill_q[gs_q] + nbytes(cfg_q[B+gs_q].ssize);
								rem_q[gs_q]  <= rem_q[gs_q] - 16'h0001;
								if (cfg_q[B+gs_q].dir == msd_pkg::DIR_M2P) begin
									ma_q[gs_q] <= ma_q[gs_q] + nbytes(cfg_q[B+gs_q].ssize);
								end else if (cfg_q[B+gs_q].dir == msd_pkg::DIR_M2M) begin
									pa_q[gs_q] <= pa_q[gs_q] + nbytes(cfg_q[B+gs_q].ssize);
								end
								if (rem_q[gs_q] - 16'h0001 == (cnt_q[B+gs_q] >> 1)) begin
									ht_q[gs_q] <= 1'b1;
								end
							end
						end
					end
				endcase
			end
		end

		assign mreq[c]         = mq_q;
		assign ev_ht[B +: NS]  = ht_q;
		assign ev_tc[B +: NS]  = tc_q;
		assign ev_te[B +: NS]  = te_q;
		assign done[B +: NS]   = dn_q;
		assign ct[B +: NS]     = ct_q;
	end
endmodule

// ---- hw/msd_pkg.sv ----
package msd_pkg;
	// ============================================================
	// Topology and buffering
	localparam int unsigned NCTRL    = 2;
	localparam int unsigned NSTR     = 8;
	localparam int unsigned BURST    = 4;
	localparam logic [3:0]  BUFB     = 4'h8;

	// ============================================================
	// Register map (byte addresses)
	localparam int unsigned CSEL_BIT = 10;
	localparam logic [9:0]  STR_SPAN = 10'h100;
	localparam logic [9:0]  OFS_STAT = 10'h300;
	localparam logic [9:0]  OFS_MASK = 10'h304;
	localparam logic [4:0]  OFS_CFG  = 5'h00;
	localparam logic [4:0]  OFS_CNT  = 5'h04;
	localparam logic [4:0]  OFS_PADR = 5'h08;
	localparam logic [4:0]  OFS_M0   = 5'h0C;
	localparam logic [4:0]  OFS_M1   = 5'h10;

	// ============================================================
	// Flag layout: four bits per stream in status and mask
	localparam int unsigned FLG_HT   = 0;
	localparam int unsigned FLG_TC   = 1;
	localparam int unsigned FLG_TE   = 2;
	localparam int unsigned FLG_W    = 4;

	// ============================================================
	// Reset values
	localparam logic [31:0] REG_RST  = 32'h0000_0000;
	localparam logic [15:0] CNT_RST  = 16'h0000;

	// ============================================================
	// Types
	typedef enum logic [1:0] {
		DIR_P2M = 2'h0,
		DIR_M2P = 2'h1,
		DIR_M2M = 2'h2
	} msd_dir_t;

	typedef enum {ST_IDLE, ST_XFER} msd_state_t;

	typedef struct packed {
		logic [18:0] rsvd;
		logic        ct;
		logic [1:0]  dsize;
		logic [1:0]  ssize;
		logic [1:0]  prio;
		logic        swreq;
		logic        dbm;
		logic        circ;
		msd_dir_t    dir;
		logic        en;
	} msd_cfg_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} msd_mreq_t;

	typedef struct packed {
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} msd_mrsp_t;
endpackage

// ---- verification/msd_dma_asserts.sv ----
`timescale 1ns/1ps
// ============================================================
// Port checks for the transfer engine
module msd_dma_asserts #(
	parameter int unsigned BURST = 4
) (
	input logic               pclk,
	input logic               presetn,
	input logic               psel,
	input logic               penable,
	input logic               pwrite,
	input logic [11:0]        paddr,
	input logic [31:0]        prdata,
	input logic               pready,
	input logic               pslverr,
	input msd_pkg::msd_mreq_t mreq [msd_pkg::NCTRL],
	input msd_pkg::msd_mrsp_t mrsp [msd_pkg::NCTRL],
	input logic               irq
);
	// Completed register write
	logic apb_wr;
	assign apb_wr = psel && penable && pwrite;

	a_ready_const: assert property (@(posedge pclk) disable iff (!presetn) pready)
		else $error("pready low");
	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && paddr[11] |=> pslverr) else $error("no slave error");
	a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr[11] |=> prdata == 32'h0) else $error("unmapped data");
	a_beat_hold0: assert property (@(posedge pclk) disable iff (!presetn)
		mreq[0].valid && !mrsp[0].ready |=> mreq[0].valid && $stable(mreq[0].addr)
		&& $stable(mreq[0].wdata)) else $error("beat 0 changed");
	a_beat_hold1: assert property (@(posedge pclk) disable iff (!presetn)
		mreq[1].valid && !mrsp[1].ready |=> mreq[1].valid && $stable(mreq[1].addr)
		&& $stable(mreq[1].size)) else $error("beat 1 changed");
	a_beat_gap: assert property (@(posedge pclk) disable iff (!presetn)
		mreq[0].valid && mrsp[0].ready |=> !mreq[0].valid) else $error("no beat gap");
	a_size_legal: assert property (@(posedge pclk) disable iff (!presetn)
		mreq[1].valid |-> mreq[1].size != 2'h3) else $error("bad size");
	a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(irq) |-> $past(apb_wr) || $past(apb_wr, 2)) else $error("irq fell alone");
endmodule

bind msd_dma msd_dma_asserts #(.BURST(BURST)) msd_dma_asserts_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mreq(mreq), .mrsp(mrsp), .irq(irq));

// ---- verification/msd_dma_tb.sv ----
`timescale 1ns/1ps
// ============================================================
// Register-level tests of the transfer engine
module msd_dma_tb;
	logic               pclk;
	logic               presetn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [11:0]        paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [15:0]        periph_req;
	msd_pkg::msd_mreq_t mreq [msd_pkg::NCTRL];
	msd_pkg::msd_mrsp_t mrsp [msd_pkg::NCTRL];
	logic               irq;
	logic [31:0]        d;
	logic               er;
	int                 error_cnt;
	int                 total_checks;

	msd_dma msd_dma_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_req(periph_req), .mreq(mreq), .mrsp(mrsp), .irq(irq));
	// Fast memory on one port, slow on the other
	msd_mem_model mem0_inst (.pclk(pclk), .presetn(presetn), .dly(4'h0), .mreq(mreq[0]),
		.mrsp(mrsp[0]));
	msd_mem_model mem1_inst (.pclk(pclk), .presetn(presetn), .dly(4'h3), .mreq(mreq[1]),
		.mrsp(mrsp[1]));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; an idle edge follows so strobes are never driven twice at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd_o, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_o = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, v, x, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		logic e;
		apb(1'b0, a, 32'h0, v, e);
	endtask

	function automatic logic [11:0] ra(input int c, input int s, input logic [4:0] o);
		return 12'(c * 1024 + s * 32) + {7'h00, o};
	endfunction

	function automatic logic [11:0] st(input int c, input logic [9:0] o);
		return 12'(c * 1024) + {2'h0, o};
	endfunction

	// Poll a register until all mask bits are set, bounded
	task automatic poll(input logic [11:0] a, input logic [31:0] m);
		logic [31:0] v;
		int n;
		n = 0;
		do begin
			rd(a, v);
			n++;
		end while ((v & m) !== m && n < 200);
	endtask

	// Hang guard, well above the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_sim();
	end

	// ============================================================
	// Test sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		periph_req = 16'h0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(st(0, msd_pkg::OFS_STAT), d);
		chk(d, msd_pkg::REG_RST);
		rd(ra(1, 7, msd_pkg::OFS_CFG), d);
		chk(d, msd_pkg::REG_RST);
		wr(ra(1, 7, msd_pkg::OFS_PADR), 32'hCAFE_0004);
		rd(ra(1, 7, msd_pkg::OFS_PADR), d);
		chk(d, 32'hCAFE_0004);
		wr(ra(1, 7, msd_pkg::OFS_CFG), 32'h0000_16C0);
		rd(ra(1, 7, msd_pkg::OFS_CFG), d);
		chk(d, 32'h0000_06C0);
		apb(1'b0, 12'h800, 32'h0, d, er);
		chk(d, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h804, 32'hFFFF_FFFF, d, er);
		chk({31'h0, er}, 32'h1);
		// Word source packed into byte writes, second controller, slow memory
		for (int i = 0; i < 8; i++) mem1_inst.mem[i] = 8'(8'h11 * (i + 1));
		wr(ra(1, 0, msd_pkg::OFS_PADR), 32'h0);
		wr(ra(1, 0, msd_pkg::OFS_M0), 32'h80);
		wr(ra(1, 0, msd_pkg::OFS_CNT), 32'h2);
		wr(st(1, msd_pkg::OFS_MASK), 32'h2);
		wr(ra(1, 0, msd_pkg::OFS_CFG), 32'h205);
		poll(st(1, msd_pkg::OFS_STAT), 32'h2);
		rd(st(1, msd_pkg::OFS_STAT), d);
		chk(d, 32'h3);
		chk({31'h0, irq}, 32'h1);
		for (int i = 0; i < 8; i++) chk({24'h0, mem1_inst.mem[8'h80 + i]}, 32'(8'h11 * (i + 1)));
		rd(ra(1, 0, msd_pkg::OFS_CFG), d);
		chk(d, 32'h204);
		wr(st(1, msd_pkg::OFS_STAT), 32'h3);
		rd(st(1, msd_pkg::OFS_STAT), d);
		chk(d, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Software-started read from the error region
		wr(st(0, msd_pkg::OFS_MASK), 32'h0040_0000);
		wr(ra(0, 5, msd_pkg::OFS_M0), 32'hF000_0000);
		wr(ra(0, 5, msd_pkg::OFS_PADR), 32'h20);
		wr(ra(0, 5, msd_pkg::OFS_CNT), 32'h1);
		wr(ra(0, 5, msd_pkg::OFS_CFG), 32'h23);
		poll(st(0, msd_pkg::OFS_STAT), 32'h0040_0000);
		rd(st(0, msd_pkg::OFS_STAT), d);
		chk(d, 32'h0040_0000);
		chk({31'h0, irq}, 32'h1);
		rd(ra(0, 5, msd_pkg::OFS_CFG), d);
		chk(d, 32'h22);
		wr(st(0, msd_pkg::OFS_STAT), 32'h0040_0000);
		// Hardware request, fixed source, masked flags
		mem0_inst.mem[8'h10] = 8'hA5;
		wr(ra(0, 2, msd_pkg::OFS_PADR), 32'h10);
		wr(ra(0, 2, msd_pkg::OFS_M0), 32'h40);
		wr(ra(0, 2, msd_pkg::OFS_CNT), 32'h3);
		wr(ra(0, 2, msd_pkg::OFS_CFG), 32'h1);
		periph_req[2] <= 1'b1;
		poll(st(0, msd_pkg::OFS_STAT), 32'h200);
		periph_req[2] <= 1'b0;
		rd(st(0, msd_pkg::OFS_STAT), d);
		chk(d, 32'h300);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 4; i++) chk({24'h0, mem0_inst.mem[8'h40 + i]}, (i < 3) ? 32'hA5 : 32'h0);
		wr(st(0, msd_pkg::OFS_STAT), 32'h300);
		// Double buffering: second buffer reached without software
		mem0_inst.mem[8'h11] = 8'h5A;
		wr(ra(0, 3, msd_pkg::OFS_PADR), 32'h11);
		wr(ra(0, 3, msd_pkg::OFS_M0), 32'h60);
		wr(ra(0, 3, msd_pkg::OFS_M1), 32'h70);
		wr(ra(0, 3, msd_pkg::OFS_CNT), 32'h1);
		wr(ra(0, 3, msd_pkg::OFS_CFG), 32'h11);
		periph_req[3] <= 1'b1;
		poll(ra(0, 3, msd_pkg::OFS_CFG), 32'h1000);
		wr(st(0, msd_pkg::OFS_STAT), 32'hF000);
		poll(st(0, msd_pkg::OFS_STAT), 32'h2000);
		periph_req[3] <= 1'b0;
		wr(ra(0, 3, msd_pkg::OFS_CFG), 32'h0);
		chk({24'h0, mem0_inst.mem[8'h60]}, 32'h5A);
		chk({24'h0, mem0_inst.mem[8'h70]}, 32'h5A);
		// Circular byte-to-word copy: a second completion proves the reload
		wr(ra(1, 1, msd_pkg::OFS_PADR), 32'h0);
		wr(ra(1, 1, msd_pkg::OFS_M0), 32'h40);
		wr(ra(1, 1, msd_pkg::OFS_CNT), 32'h4);
		wr(ra(1, 1, msd_pkg::OFS_CFG), 32'h0000_080D);
		poll(st(1, msd_pkg::OFS_STAT), 32'h20);
		wr(st(1, msd_pkg::OFS_STAT), 32'hF0);
		poll(st(1, msd_pkg::OFS_STAT), 32'h20);
		rd(st(1, msd_pkg::OFS_STAT), d);
		chk(d & 32'h20, 32'h20);
		rd(ra(1, 1, msd_pkg::OFS_CFG), d);
		chk(d, 32'h0000_080D);
		wr(ra(1, 1, msd_pkg::OFS_CFG), 32'h0);
		for (int i = 0; i < 4; i++) chk({24'h0, mem1_inst.mem[8'h40 + i]}, 32'(8'h11 * (i + 1)));
		end_sim();
	end
endmodule

// ---- verification/msd_mem_model.sv ----
`timescale 1ns/1ps
// ============================================================
// Bus matrix slave: byte memory, programmable wait, error region
module msd_mem_model (
	input  logic               pclk,
	input  logic               presetn,
	input  logic [3:0]         dly,
	input  msd_pkg::msd_mreq_t mreq,
	output msd_pkg::msd_mrsp_t mrsp
);
	logic [7:0] mem [256];
	logic [3:0] cnt_q;
	logic [7:0] a;

	assign a = mreq.addr[7:0];
	initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;

	// Answer after dly waits; read lanes toggle outside a beat so stale data never looks valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mrsp <= '0;
			cnt_q <= 4'h0;
		end else if (mreq.valid && !mrsp.ready && cnt_q == dly) begin
			mrsp.ready <= 1'b1;
			mrsp.err <= (mreq.addr[31:28] == 4'hF);
			mrsp.rdata <= {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]};
			cnt_q <= 4'h0;
			if (mreq.write) for (int i = 0; i < (1 << mreq.size); i++) mem[a + i[7:0]] <= mreq.wdata[8*i +: 8];
		end else begin
			mrsp.ready <= 1'b0;
			mrsp.err <= 1'b0;
			mrsp.rdata <= ~mrsp.rdata;
			cnt_q <= (mreq.valid && !mrsp.ready) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule
